// ==== shared/scs_pkg.sv ====
// package: register map, fields, resets and timing of the clock control
package scs_pkg;
  // register addresses on the serial control port
  localparam logic [14:0] ADDR_NOISE = 15'h002B;
  localparam logic [14:0] ADDR_DIV_PRI = 15'h003D;
  localparam logic [14:0] ADDR_DIV_FB = 15'h003E;
  localparam logic [14:0] ADDR_HOLD = 15'h005C;
  localparam logic [14:0] ADDR_CAL_CTRL = 15'h005D;
  localparam logic [14:0] ADDR_CAL_STAT = 15'h005E;
  localparam logic [14:0] ADDR_LINK_STAT = 15'h0208;
  localparam logic [14:0] ADDR_OUT_CTRL = 15'h0060;
  localparam logic [14:0] ADDR_RX_DIV = 15'h0061;
  localparam logic [14:0] ADDR_SYSREF_WIN = 15'h0062;

  // field positions
  localparam int HOLD_BIT = 0;
  localparam int CAL_START_BIT = 0;
  localparam int CAL_DONE_BIT = 0;
  localparam int LOCK_BIT = 0;
  localparam int PRESCALE_LSB = 4;
  localparam int VCO_DIV_LSB = 0;
  localparam int REPEAT_EN_BIT = 0;
  localparam int TRIG_EN_BIT = 1;
  localparam int AUX_OVR_BIT = 2;
  localparam int AUX_C_MODE_LSB = 3;
  localparam int AUX_D_EN_BIT = 5;

  // reset values
  localparam logic [7:0] NOISE_RST = 8'h00;
  localparam logic [7:0] DIV_PRI_RST = 8'h25;
  localparam logic [7:0] DIV_FB_RST = 8'h08;
  localparam logic [7:0] HOLD_RST = 8'h00;
  localparam logic [7:0] CAL_CTRL_RST = 8'h01;
  localparam logic [7:0] OUT_CTRL_RST = 8'h01;
  localparam logic [7:0] RX_DIV_RST = 8'h01;
  localparam logic [10:0] PIN_SYNC_RST = 11'h100;

  // supported combined vco divisors
  localparam logic [7:0] VCO_DIV_A = 8'h0A;
  localparam logic [7:0] VCO_DIV_B = 8'h0C;
  localparam logic [7:0] VCO_DIV_C = 8'h10;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CAL_TIME_NS = 2000;
  localparam int LOCK_TIME_NS = 1000;
  localparam int CAL_CYCLES =
    (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CYCLES =
    (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPI_FRAME_BITS = 24;

  // synthesizer sequence states
  typedef enum logic [1:0] {
    ST_HOLD, ST_CAL, ST_LOCKWAIT, ST_LOCKED
  } scs_state_type;
endpackage

// ==== rtl/scs_clock_ctrl.sv ====
// sampling clock selection, synthesizer sequencing and clock output control
//
// Contract
// R1: synth-enable pin high: sampling clock comes from the synthesizer
// R2: synth on: select pin high takes single-ended ref, else differential
// R3: both pins low: bypass, differential input is the sampling clock
// R4: board never relies on single-ended ref while bypassed
// R5: synth on: selected reference repeats on the repeat output
// R6: aux outputs give reference or divided copies via straps or registers
// R7: repeat and aux outputs run from power-up if selected, powerdown low
// R8: powerdown high also silences repeat and aux clock outputs
// R9: serial clock from sampling clock; a divided copy may feed trigger
// R10: sysref captured by selected clock; window logs setup and hold
// R11: selected sampling clock drives cores, digital logic, serial synth
// R12: rate = vco / (divider x prescaler) = reference x feedback divider
// R13: only combined vco divisors 10, 12 and 16 when synthesizing
// R14: system bypasses synth, feeds clock directly, for unsupported rates
// R15: software sets hold bit before changing any synthesizer setting
// R16: prescaler and vco divider writable at 0x3D, feedback divider at 0x3E
// R17: software arms tuning calibration at 0x5D after programming dividers
// R18: armed calibration runs when the hold bit is cleared
// R19: completion reads 1 in calibration-complete at 0x5E and lock at 0x208
// R20: supply-noise suppression options selectable through bits at 0x2B
// R21: repeat output on with synthesizer; enable bit written 0 turns it off
// R22: trigger off after startup until enabled; rate set by receiver divider
// R23: status bits read 0 while synthesizer is held or calibrating
// R24: software polls both status bits, with timeout, before using the clock
`timescale 1ns/1ps
`default_nettype none
module scs_clock_ctrl (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  // configuration pins
  input wire logic SYNTH_EN_PIN,
  input wire logic SINGLE_ENDED_REF_SELECT_PIN,
  input wire logic [1:0] AUX_CLOCK_STRAP_PINS,
  input wire logic POWERDOWN_PIN,
  // clock and sync inputs
  input wire logic DIFF_CLK_IN,
  input wire logic SINGLE_ENDED_REF_IN,
  input wire logic SYSREF_IN,
  // serial control port
  input wire logic SPI_SCLK,
  input wire logic SPI_CS_N,
  input wire logic SPI_SDI,
  output logic SPI_SDO,
  // clock outputs
  output logic SAMPLE_CLK_OUT,
  output logic REF_CLOCK_REPEAT_OUT,
  output logic AUX_CLOCK_OUT_C,
  output logic AUX_CLOCK_OUT_D,
  output logic TRIGGER_CLOCK_OUT,
  // status and options
  output logic SYSREF_CAPTURE_OUT,
  output logic [1:0] NOISE_SUPPRESS_OUT
);

  logic [10:0] meta_reg;
  logic [10:0] sync_reg;
  logic synth_en, ref_sel, pd, diff_s, se_s, sclk_s, cs_n_s, sdi_s, sysref_s;
  logic [1:0] strap;
  logic sclk_d_reg, sysref_prev_reg;
  logic [4:0] bit_cnt_reg;
  logic [22:0] sh_reg;
  logic [7:0] rd_sh_reg;
  logic [7:0] rd_data;
  logic [14:0] rd_addr, wr_addr;
  logic [7:0] wr_data;
  logic sclk_rise, sclk_fall, wr_stb, rd_load;
  logic [7:0] noise_reg, div_pri_reg, div_fb_reg, hold_reg, cal_ctrl_reg;
  logic [7:0] out_ctrl_reg, rx_div_reg;
  logic [1:0] win_reg;
  scs_pkg::scs_state_type state_reg, state_next;
  logic [7:0] cnt_reg;
  logic done_reg;
  logic [7:0] vco_div;
  logic div_ok, hold, lock;
  logic ref_lvl, samp_lvl, samp_prev_reg, ref_prev_reg, samp_rise, ref_rise;
  logic [1:0] ref_div_reg;
  logic [7:0] trig_cnt_reg;
  logic trig_tgl_reg;
  logic aux_c_next, aux_d_next;
  logic [1:0] c_mode;

  // two-stage synchroniser for every input pin except CLK, RSTN and CE
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      meta_reg <= scs_pkg::PIN_SYNC_RST;
      sync_reg <= scs_pkg::PIN_SYNC_RST;
    end else if (CE) begin
      meta_reg <= {SYSREF_IN, SPI_SDI, SPI_CS_N, SPI_SCLK, SINGLE_ENDED_REF_IN,
                   DIFF_CLK_IN, POWERDOWN_PIN, AUX_CLOCK_STRAP_PINS,
                   SINGLE_ENDED_REF_SELECT_PIN, SYNTH_EN_PIN};
      sync_reg <= meta_reg;
    end
  end

  assign synth_en = sync_reg[0];
  assign ref_sel = sync_reg[1];
  assign strap = sync_reg[3:2];
  assign pd = sync_reg[4];
  assign diff_s = sync_reg[5];
  assign se_s = sync_reg[6];
  assign sclk_s = sync_reg[7];
  assign cs_n_s = sync_reg[8];
  assign sdi_s = sync_reg[9];
  assign sysref_s = sync_reg[10];

  // serial port framing: r/w bit, 15-bit address, 8 data bits, msb first
  assign sclk_rise = sclk_s && !sclk_d_reg && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_d_reg && !cs_n_s;
  assign rd_addr = {sh_reg[13:0], sdi_s};
  assign rd_load = sclk_rise && bit_cnt_reg == 5'h0F && sh_reg[14];
  assign wr_addr = sh_reg[21:7];
  assign wr_data = {sh_reg[6:0], sdi_s};
  assign wr_stb = sclk_rise && bit_cnt_reg == 5'(scs_pkg::SPI_FRAME_BITS - 1)
                  && !sh_reg[22];

  // shift register and bit counter; chip select high restarts the frame
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      sclk_d_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      sh_reg <= 23'h000000;
    end else if (CE) begin
      sclk_d_reg <= sclk_s;
      if (cs_n_s) begin
        bit_cnt_reg <= 5'h00;
      end else if (sclk_rise) begin
        sh_reg <= {sh_reg[21:0], sdi_s};
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // read data path; unmapped addresses read as zero
  always_comb begin
    rd_data = 8'h00;
    case (rd_addr)
      scs_pkg::ADDR_NOISE: rd_data = noise_reg;
      scs_pkg::ADDR_DIV_PRI: rd_data = div_pri_reg;
      scs_pkg::ADDR_DIV_FB: rd_data = div_fb_reg;
      scs_pkg::ADDR_HOLD: rd_data = hold_reg;
      scs_pkg::ADDR_CAL_CTRL: rd_data = cal_ctrl_reg;
      scs_pkg::ADDR_CAL_STAT: rd_data[scs_pkg::CAL_DONE_BIT] = done_reg; // R19
      scs_pkg::ADDR_LINK_STAT: rd_data[scs_pkg::LOCK_BIT] = lock; // R19
      scs_pkg::ADDR_OUT_CTRL: rd_data = out_ctrl_reg;
      scs_pkg::ADDR_RX_DIV: rd_data = rx_div_reg;
      scs_pkg::ADDR_SYSREF_WIN: rd_data = {6'h00, win_reg};
      default: rd_data = 8'h00;
    endcase
  end

  // read data leaves on falling edges so it is stable at the next rising edge
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rd_sh_reg <= 8'h00;
      SPI_SDO <= 1'b0;
    end else if (CE) begin
      if (rd_load) begin
        rd_sh_reg <= rd_data;
      end else if (sclk_fall && bit_cnt_reg >= 5'h10) begin
        SPI_SDO <= rd_sh_reg[7];
        rd_sh_reg <= {rd_sh_reg[6:0], 1'b0};
      end
    end
  end

  // writable registers; read-only and unmapped addresses drop the write
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      noise_reg <= scs_pkg::NOISE_RST;
      div_pri_reg <= scs_pkg::DIV_PRI_RST;
      div_fb_reg <= scs_pkg::DIV_FB_RST;
      hold_reg <= scs_pkg::HOLD_RST;
      cal_ctrl_reg <= scs_pkg::CAL_CTRL_RST;
      out_ctrl_reg <= scs_pkg::OUT_CTRL_RST;
      rx_div_reg <= scs_pkg::RX_DIV_RST;
    end else if (CE && wr_stb) begin
      case (wr_addr)
        scs_pkg::ADDR_NOISE: noise_reg <= wr_data; // R20
        scs_pkg::ADDR_DIV_PRI: div_pri_reg <= wr_data; // R16
        scs_pkg::ADDR_DIV_FB: div_fb_reg <= wr_data; // R16
        scs_pkg::ADDR_HOLD: hold_reg <= wr_data;
        scs_pkg::ADDR_CAL_CTRL: cal_ctrl_reg <= wr_data;
        scs_pkg::ADDR_OUT_CTRL: out_ctrl_reg <= wr_data;
        scs_pkg::ADDR_RX_DIV: rx_div_reg <= wr_data;
        default: ;
      endcase
    end
  end

  // noise suppression options go straight to the analog trim
  assign NOISE_SUPPRESS_OUT = noise_reg[1:0]; // R20

  // combined divisor check; feedback divider only scales the reference
  assign vco_div = 8'(div_pri_reg[7:scs_pkg::PRESCALE_LSB]
                   * div_pri_reg[scs_pkg::PRESCALE_LSB-1:
                                 scs_pkg::VCO_DIV_LSB]); // R12
  assign div_ok = (vco_div == scs_pkg::VCO_DIV_A)
                  || (vco_div == scs_pkg::VCO_DIV_B)
                  || (vco_div == scs_pkg::VCO_DIV_C); // R13
  assign hold = hold_reg[scs_pkg::HOLD_BIT];
  assign lock = state_reg == scs_pkg::ST_LOCKED;

  // synthesizer sequence: hold, optional calibration, lock wait, locked
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      scs_pkg::ST_HOLD: begin
        if (synth_en && !hold) begin
          state_next = cal_ctrl_reg[scs_pkg::CAL_START_BIT]
                       ? scs_pkg::ST_CAL : scs_pkg::ST_LOCKWAIT; // R18
        end
      end
      scs_pkg::ST_CAL: begin
        if (cnt_reg == 8'(scs_pkg::CAL_CYCLES - 1)) begin
          state_next = scs_pkg::ST_LOCKWAIT;
        end
      end
      scs_pkg::ST_LOCKWAIT: begin
        if (div_ok && cnt_reg == 8'(scs_pkg::LOCK_CYCLES - 1)) begin
          state_next = scs_pkg::ST_LOCKED;
        end
      end
      scs_pkg::ST_LOCKED: begin
        if (!div_ok) begin
          state_next = scs_pkg::ST_LOCKWAIT; // R13
        end
      end
      default: state_next = scs_pkg::ST_HOLD;
    endcase
    if (!synth_en || hold) begin
      state_next = scs_pkg::ST_HOLD;
    end
  end

  // state, dwell counter and the sticky calibration-complete flag
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state_reg <= scs_pkg::ST_HOLD;
      cnt_reg <= 8'h00;
      done_reg <= 1'b0;
    end else if (CE) begin
      state_reg <= state_next;
      if (state_next != state_reg
          || (state_reg == scs_pkg::ST_LOCKWAIT && !div_ok)) begin
        cnt_reg <= 8'h00;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
      if (state_next == scs_pkg::ST_HOLD || state_next == scs_pkg::ST_CAL) begin
        done_reg <= 1'b0; // R23
      end else if (state_reg == scs_pkg::ST_CAL) begin
        done_reg <= 1'b1; // R19
      end
    end
  end

  // clock selection; the synthesized clock is modelled by the reference
  // gated on lock, since a 25 MHz fabric cannot multiply frequency
  assign ref_lvl = ref_sel ? se_s : diff_s; // R2
  assign samp_lvl = synth_en ? (lock && ref_lvl) : diff_s; // R1 R3
  assign samp_rise = samp_lvl && !samp_prev_reg;
  assign ref_rise = ref_lvl && !ref_prev_reg;

  // edge history and the reference divider for the aux outputs
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      samp_prev_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
      ref_div_reg <= 2'h0;
    end else if (CE) begin
      samp_prev_reg <= samp_lvl;
      ref_prev_reg <= ref_lvl;
      if (ref_rise) begin
        ref_div_reg <= ref_div_reg + 2'h1;
      end
    end
  end

  // aux routing: straps unless the override bit hands control to software;
  // output d only runs while output c is enabled
  assign c_mode = out_ctrl_reg[scs_pkg::AUX_OVR_BIT]
                  ? out_ctrl_reg[scs_pkg::AUX_C_MODE_LSB +: 2] : strap;
  always_comb begin
    case (c_mode)
      2'h1: aux_c_next = ref_lvl;
      2'h2: aux_c_next = ref_div_reg[0];
      2'h3: aux_c_next = ref_div_reg[1];
      default: aux_c_next = 1'b0;
    endcase
    aux_d_next = (c_mode != 2'h0) && ref_lvl
                 && (!out_ctrl_reg[scs_pkg::AUX_OVR_BIT]
                     || out_ctrl_reg[scs_pkg::AUX_D_EN_BIT]);
  end

  // registered clock outputs; powerdown forces the repeat and aux copies low, not the sampling clock
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      SAMPLE_CLK_OUT <= 1'b0;
      REF_CLOCK_REPEAT_OUT <= 1'b0;
      AUX_CLOCK_OUT_C <= 1'b0;
      AUX_CLOCK_OUT_D <= 1'b0;
    end else if (CE) begin
      SAMPLE_CLK_OUT <= samp_lvl; // R11
      REF_CLOCK_REPEAT_OUT <= synth_en && out_ctrl_reg[scs_pkg::REPEAT_EN_BIT]
                              && !pd && ref_lvl; // R5 R21 R7 R8
      AUX_CLOCK_OUT_C <= !pd && aux_c_next; // R6 R7 R8
      AUX_CLOCK_OUT_D <= !pd && aux_d_next; // R6 R8
    end
  end

  // trigger clock: sampling clock divided by twice the receiver divider
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      trig_cnt_reg <= 8'h00;
      trig_tgl_reg <= 1'b0;
      TRIGGER_CLOCK_OUT <= 1'b0;
    end else if (CE) begin
      if (samp_rise) begin
        if (trig_cnt_reg + 8'h01 >= rx_div_reg) begin
          trig_cnt_reg <= 8'h00;
          trig_tgl_reg <= !trig_tgl_reg; // R9
        end else begin
          trig_cnt_reg <= trig_cnt_reg + 8'h01;
        end
      end
      TRIGGER_CLOCK_OUT <= out_ctrl_reg[scs_pkg::TRIG_EN_BIT] && !pd
                           && trig_tgl_reg; // R22
    end
  end

  // sysref capture on each sampling edge; the window keeps the level just
  // before and at the edge, a mismatch flags a setup hazard
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      sysref_prev_reg <= 1'b0;
      win_reg <= 2'h0;
      SYSREF_CAPTURE_OUT <= 1'b0;
    end else if (CE) begin
      sysref_prev_reg <= sysref_s;
      SYSREF_CAPTURE_OUT <= samp_rise && sysref_s; // R10
      if (samp_rise) begin
        win_reg <= {sysref_prev_reg, sysref_s}; // R10
      end
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence hold_release;
    CE && state_reg == scs_pkg::ST_HOLD && synth_en && !hold;
  endsequence
  sequence cal_finish;
    CE && state_reg == scs_pkg::ST_CAL && synth_en && !hold
      && cnt_reg == 8'(scs_pkg::CAL_CYCLES - 1);
  endsequence

  chk_bypass_route: assert property ( // R3
    (CE && !synth_en) |=> SAMPLE_CLK_OUT == $past(diff_s))
    else $error("bypass does not pass differential clock");
  chk_synth_route: assert property ( // R1
    (CE && synth_en) |=> SAMPLE_CLK_OUT == $past(lock && ref_lvl))
    else $error("synthesized clock not gated by lock");
  chk_repeat_select: assert property ( // R2
    (CE && synth_en && ref_sel && !pd && out_ctrl_reg[scs_pkg::REPEAT_EN_BIT])
      |=> REF_CLOCK_REPEAT_OUT == $past(se_s))
    else $error("repeat output not single-ended reference");
  chk_pd_quiet: assert property ( // R8
    (CE && pd) |=> !REF_CLOCK_REPEAT_OUT && !AUX_CLOCK_OUT_C
      && !AUX_CLOCK_OUT_D && !TRIGGER_CLOCK_OUT)
    else $error("clock output active in powerdown");
  chk_repeat_off: assert property ( // R21
    (CE && !out_ctrl_reg[scs_pkg::REPEAT_EN_BIT]) |=> !REF_CLOCK_REPEAT_OUT)
    else $error("repeat output not disabled by register");
  chk_aux_strap: assert property ( // R6
    (CE && !pd && !out_ctrl_reg[scs_pkg::AUX_OVR_BIT] && strap == 2'h1)
      |=> AUX_CLOCK_OUT_C == $past(ref_lvl))
    else $error("aux c does not follow reference");
  chk_status_zero: assert property ( // R23
    (state_reg == scs_pkg::ST_HOLD || state_reg == scs_pkg::ST_CAL)
      |-> !done_reg && !lock)
    else $error("status set while held or calibrating");
  chk_cal_start: assert property ( // R18
    (hold_release ##0 cal_ctrl_reg[scs_pkg::CAL_START_BIT])
      |=> state_reg == scs_pkg::ST_CAL)
    else $error("armed calibration did not start on release");
  chk_cal_done: assert property ( // R19
    cal_finish |=> done_reg && state_reg == scs_pkg::ST_LOCKWAIT)
    else $error("calibration did not complete on time");
  chk_lock_divisor: assert property ( // R13
    (CE && lock && !div_ok) |=> !lock)
    else $error("lock held with unsupported divisor");
  chk_trig_off: assert property ( // R22
    (CE && !out_ctrl_reg[scs_pkg::TRIG_EN_BIT]) |=> !TRIGGER_CLOCK_OUT)
    else $error("trigger output active while disabled");
  chk_div_write: assert property ( // R16
    (CE && wr_stb && wr_addr == scs_pkg::ADDR_DIV_PRI)
      |=> div_pri_reg == $past(wr_data))
    else $error("divider write lost");
  chk_sysref_win: assert property ( // R10
    (CE && samp_rise) |=> win_reg == $past({sysref_prev_reg, sysref_s}))
    else $error("sysref window not captured");

endmodule
`default_nettype wire

// ==== verif/scs_board_model.sv ====
// board model: free-running reference sources driven toward the device pins
`timescale 1ns/1ps
`default_nettype none
module scs_board_model (
  // pacing clock
  input wire logic clk,
  // reference clock pins
  output var logic diff_clk,
  output var logic se_ref
);
  logic [1:0] se_cnt_reg;
  // both sources start low so the first compare window is defined; one
  // process owns both pins so each has a single driver
  initial begin
    diff_clk = 1'b0;
    se_ref = 1'b0;
    se_cnt_reg = 2'h0;
    forever begin
      @(posedge clk);
      #1;
      // differential source runs free so it can also be the direct
      // sampling clock whenever the synthesizer is bypassed
      diff_clk = ~diff_clk;
      // single-ended source toggles every third clock so the two sources
      // can be told apart; it runs in bypass but nothing may lean on it
      if (se_cnt_reg == 2'h2) begin
        se_ref = ~se_ref;
        se_cnt_reg = 2'h0;
      end else begin
        se_cnt_reg = se_cnt_reg + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the sampling clock control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic CLK = 1'b0, RSTN = 1'b0, CE = 1'b1, SYNTH_EN_PIN = 1'b1;
  logic SINGLE_ENDED_REF_SELECT_PIN = 1'b0, POWERDOWN_PIN = 1'b0;
  logic SPI_SCLK = 1'b0, SPI_CS_N = 1'b1, SPI_SDI = 1'b0, SYSREF_IN = 1'b0;
  logic [1:0] AUX_CLOCK_STRAP_PINS = 2'h0;
  wire logic DIFF_CLK_IN, SINGLE_ENDED_REF_IN, SPI_SDO, SAMPLE_CLK_OUT;
  wire logic REF_CLOCK_REPEAT_OUT, AUX_CLOCK_OUT_C, AUX_CLOCK_OUT_D;
  wire logic TRIGGER_CLOCK_OUT, SYSREF_CAPTURE_OUT;
  wire logic [1:0] NOISE_SUPPRESS_OUT;
  wire logic [3:0] outs;
  logic [2:0] dhist = 3'h0, shist = 3'h0;
  logic [7:0] rdv;
  int n_mismatch = 0, num_checks = 0, cycles = 0;

  scs_board_model board_u (.clk(CLK), .diff_clk(DIFF_CLK_IN),
    .se_ref(SINGLE_ENDED_REF_IN));
  scs_clock_ctrl dut_u (.CLK(CLK), .RSTN(RSTN), .CE(CE),
    .SYNTH_EN_PIN(SYNTH_EN_PIN),
    .SINGLE_ENDED_REF_SELECT_PIN(SINGLE_ENDED_REF_SELECT_PIN),
    .AUX_CLOCK_STRAP_PINS(AUX_CLOCK_STRAP_PINS),
    .POWERDOWN_PIN(POWERDOWN_PIN), .DIFF_CLK_IN(DIFF_CLK_IN),
    .SINGLE_ENDED_REF_IN(SINGLE_ENDED_REF_IN), .SYSREF_IN(SYSREF_IN),
    .SPI_SCLK(SPI_SCLK), .SPI_CS_N(SPI_CS_N), .SPI_SDI(SPI_SDI),
    .SPI_SDO(SPI_SDO), .SAMPLE_CLK_OUT(SAMPLE_CLK_OUT),
    .REF_CLOCK_REPEAT_OUT(REF_CLOCK_REPEAT_OUT),
    .AUX_CLOCK_OUT_C(AUX_CLOCK_OUT_C), .AUX_CLOCK_OUT_D(AUX_CLOCK_OUT_D),
    .TRIGGER_CLOCK_OUT(TRIGGER_CLOCK_OUT),
    .SYSREF_CAPTURE_OUT(SYSREF_CAPTURE_OUT),
    .NOISE_SUPPRESS_OUT(NOISE_SUPPRESS_OUT));
  assign outs = {AUX_CLOCK_OUT_D, AUX_CLOCK_OUT_C, REF_CLOCK_REPEAT_OUT,
    SAMPLE_CLK_OUT};

  // system clock
  initial begin
    forever #(scs_pkg::CLK_PERIOD_NS / 2) CLK = ~CLK;
  end
  // source history for the three-edge output latency, plus hang guard
  always @(posedge CLK) begin
    dhist <= {dhist[1:0], DIFF_CLK_IN};
    shist <= {shist[1:0], SINGLE_ENDED_REF_IN};
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // inputs change one nanosecond after the edge, clear of sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic check(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // slow phases of five clocks keep every edge clear of the synchronisers
  task automatic spi(input logic rd, input logic [14:0] a,
    input logic [7:0] wd, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, wd};
    q = 8'h00;
    SPI_CS_N = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      SPI_SDI = f[i];
      cyc(5);
      if (i < 8) q[i] = SPI_SDO;
      SPI_SCLK = 1'b1;
      cyc(5);
      SPI_SCLK = 1'b0;
    end
    cyc(5);
    SPI_CS_N = 1'b1;
    cyc(5);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    spi(1'b0, a, d, rdv);
  endtask
  task automatic rd_chk(input string nm, input logic [14:0] a,
    input logic [7:0] exp);
    spi(1'b1, a, 8'h00, rdv);
    check(nm, rdv, exp);
  endtask
  // output o against source s (0 diff, 1 single-ended, 2 silent)
  task automatic follow(input string nm, input int o, input int s);
    logic e;
    int bad;
    bad = 0;
    repeat (24) begin
      @(posedge CLK);
      e = (s == 0) ? dhist[2] : (s == 1) ? shist[2] : 1'b0;
      if (outs[o] !== e) bad++;
    end
    #1;
    check(nm, 8'(bad), 8'h00);
  endtask
  // high cycles of trigger (w 0) or sysref capture (w 1); rises of aux c
  // (w 2) or of trigger (w 3), which tell the divide ratios apart
  task automatic cnt(input int w, input int n, output int c);
    logic p, v;
    c = 0;
    p = (w == 2) ? AUX_CLOCK_OUT_C : TRIGGER_CLOCK_OUT;
    repeat (n) begin
      @(posedge CLK);
      v = (w == 1) ? SYSREF_CAPTURE_OUT
        : (w == 2) ? AUX_CLOCK_OUT_C : TRIGGER_CLOCK_OUT;
      if ((w < 2) ? v : (v && !p)) c++;
      p = v;
    end
    #1;
  endtask
  // software-style poll of both status bits, bounded to four tries
  task automatic poll(output logic [7:0] d, output logic [7:0] l);
    for (int k = 0; k < 4; k++) begin
      spi(1'b1, scs_pkg::ADDR_CAL_STAT, 8'h00, d);
      spi(1'b1, scs_pkg::ADDR_LINK_STAT, 8'h00, l);
      if (d[0] && l[0]) break;
    end
  endtask

  task automatic t_reset;
    int c;
    logic [7:0] d, l;
    cnt(0, 40, c);
    check("trig_after_reset", 8'(c), 8'h00);
    rd_chk("div_pri", scs_pkg::ADDR_DIV_PRI, scs_pkg::DIV_PRI_RST);
    rd_chk("div_fb", scs_pkg::ADDR_DIV_FB, scs_pkg::DIV_FB_RST);
    rd_chk("noise", scs_pkg::ADDR_NOISE, scs_pkg::NOISE_RST);
    rd_chk("cal_ctrl", scs_pkg::ADDR_CAL_CTRL, scs_pkg::CAL_CTRL_RST);
    rd_chk("out_ctrl", scs_pkg::ADDR_OUT_CTRL, scs_pkg::OUT_CTRL_RST);
    rd_chk("rx_div", scs_pkg::ADDR_RX_DIV, scs_pkg::RX_DIV_RST);
    rd_chk("unmapped", 15'h0100, 8'h00);
    poll(d, l);
    check("boot_cal_done", {7'h00, d[0]}, 8'h01);
    check("boot_lock", {7'h00, l[0]}, 8'h01);
  endtask
  // hold, reprogram, arm, release for each divisor; 0x33 gives 9
  task automatic t_sequence;
    logic [7:0] divs [4];
    logic [3:0] ok;
    logic [7:0] d, l;
    divs = '{8'h34, 8'h44, 8'h33, 8'h25};
    ok = 4'b1101;
    for (int i = 0; i < 4; i++) begin
      wr(scs_pkg::ADDR_HOLD, 8'h01);
      wr(scs_pkg::ADDR_CAL_STAT, 8'hFF);
      rd_chk("held_cal", scs_pkg::ADDR_CAL_STAT, 8'h00);
      rd_chk("held_lock", scs_pkg::ADDR_LINK_STAT, 8'h00);
      wr(scs_pkg::ADDR_DIV_PRI, divs[i]);
      wr(scs_pkg::ADDR_DIV_FB, 8'h0A);
      rd_chk("div_pri_wr", scs_pkg::ADDR_DIV_PRI, divs[i]);
      rd_chk("div_fb_wr", scs_pkg::ADDR_DIV_FB, 8'h0A);
      wr(scs_pkg::ADDR_CAL_CTRL, 8'h01);
      wr(scs_pkg::ADDR_HOLD, 8'h00);
      poll(d, l);
      check("lock_by_divisor", {7'h00, l[0]}, {7'h00, ok[3 - i]});
      if (ok[3 - i]) check("cal_done", {7'h00, d[0]}, 8'h01);
    end
  endtask
  task automatic t_noise;
    logic [3:0] o;
    for (int v = 1; v < 3; v++) begin
      wr(scs_pkg::ADDR_NOISE, 8'(v));
      check("noise_pins", {6'h00, NOISE_SUPPRESS_OUT}, 8'(v));
    end
    // clock enable low must freeze every flop, outputs included
    CE = 1'b0;
    cyc(2);
    o = outs;
    cyc(10);
    check("ce_freeze", {4'h0, outs}, {4'h0, o});
    CE = 1'b1;
  endtask
  // locked sampling clock rises every 2 clocks: trigger period 4 x divider
  task automatic t_trigger;
    int c;
    wr(scs_pkg::ADDR_OUT_CTRL, 8'h03);
    cnt(3, 40, c);
    check("trig_rx1", 8'(c), 8'h0A);
    wr(scs_pkg::ADDR_RX_DIV, 8'h02);
    cnt(3, 40, c);
    check("trig_rx2", 8'(c), 8'h05);
    wr(scs_pkg::ADDR_OUT_CTRL, 8'h01);
  endtask
  task automatic t_modes;
    follow("smp_synth_diff", 0, 0);
    follow("rep_synth_diff", 1, 0);
    SINGLE_ENDED_REF_SELECT_PIN = 1'b1;
    cyc(120);
    follow("smp_synth_se", 0, 1);
    follow("rep_synth_se", 1, 1);
    wr(scs_pkg::ADDR_OUT_CTRL, 8'h00);
    follow("rep_disabled", 1, 2);
    wr(scs_pkg::ADDR_OUT_CTRL, 8'h01);
    SINGLE_ENDED_REF_SELECT_PIN = 1'b0;
    SYNTH_EN_PIN = 1'b0;
    cyc(120);
    follow("smp_bypass", 0, 0);
    follow("rep_bypass", 1, 2);
  endtask
  // sysref taken at sampling clock rises in bypass
  task automatic t_sysref;
    int c;
    SYSREF_IN = 1'b1;
    cyc(6);
    cnt(1, 20, c);
    check("sysref_seen", 8'(c > 0), 8'h01);
    rd_chk("sysref_win", scs_pkg::ADDR_SYSREF_WIN, 8'h03);
    SYSREF_IN = 1'b0;
    cyc(6);
    cnt(1, 20, c);
    check("sysref_quiet", 8'(c), 8'h00);
    SYNTH_EN_PIN = 1'b1;
    cyc(120);
  endtask
  task automatic t_aux;
    int c;
    AUX_CLOCK_STRAP_PINS = 2'h1;
    cyc(8);
    follow("auxc_ref", 2, 0);
    follow("auxd_ref", 3, 0);
    AUX_CLOCK_STRAP_PINS = 2'h0;
    cyc(8);
    follow("auxc_off", 2, 2);
    follow("auxd_off", 3, 2);
    // register override: c follows reference, d stays off without its bit
    wr(scs_pkg::ADDR_OUT_CTRL, 8'h0D);
    follow("auxc_reg", 2, 0);
    follow("auxd_reg", 3, 2);
    wr(scs_pkg::ADDR_OUT_CTRL, 8'h01);
    // strap 2 halves and strap 3 quarters the reference on c
    for (int m = 2; m < 4; m++) begin
      AUX_CLOCK_STRAP_PINS = 2'(m);
      cyc(8);
      cnt(2, 40, c);
      check("auxc_div", 8'(c), 8'(40 >> m));
    end
    AUX_CLOCK_STRAP_PINS = 2'h1;
    POWERDOWN_PIN = 1'b1;
    cyc(8);
    follow("rep_pd", 1, 2);
    follow("auxc_pd", 2, 2);
    follow("auxd_pd", 3, 2);
    POWERDOWN_PIN = 1'b0;
  endtask

  // main sequence
  initial begin
    cyc(6);
    RSTN = 1'b1;
    cyc(4);
    t_reset();
    t_trigger();
    t_sequence();
    t_noise();
    t_modes();
    t_sysref();
    t_aux();
    test_done();
  end
endmodule
`default_nettype wire
